// ===== src/timer_capture_compare_unit.v
// Capture/compare unit with its 16-bit timer and an AXI4-Lite register slave
`timescale 1ns/10ps
`include "ccu_map.vh"
module timer_capture_compare_unit (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        sleep,
    input  wire        ext_clock_pin,
    input  wire        capture_pin,
    input  wire        converter_enabled,
    output reg         compare_out,
    output reg         compare_oe,
    output reg         conversion_start,
    output reg         irq
);
    reg  [7:0]  capture_compare_control;
    reg  [15:0] value;
    reg  [15:0] timer_count_pair;
    reg  [1:0]  timer_cfg;
    reg  [2:0]  irq_status;
    reg  [2:0]  irq_mask;
    reg  [3:0]  prescale_count;
    reg  [1:0]  div_count;
    reg         cap_prev;
    reg         ext_prev;
    reg         timer_reset_pending;
    reg         aw_held;
    reg         w_held;
    reg  [3:0]  aw_index;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    wire        cap_level;
    wire        ext_level;
    wire [3:0]  operating_mode_field = capture_compare_control[3:0];

    pin_sync u_cap_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin_in  (capture_pin),
        .level   (cap_level)
    );

    pin_sync u_ext_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin_in  (ext_clock_pin),
        .level   (ext_level)
    );

    function is_capture;
        input [3:0] m;
        begin
            is_capture = (m == `MODE_CAP_FALL) || (m == `MODE_CAP_RISE) ||
                         (m == `MODE_CAP_RISE4) || (m == `MODE_CAP_RISE16);
        end
    endfunction

    function is_compare;
        input [3:0] m;
        begin
            is_compare = (m == `MODE_CMP_TOGGLE) || (m == `MODE_CMP_SET) ||
                         (m == `MODE_CMP_CLEAR) || (m == `MODE_CMP_SWI) ||
                         (m == `MODE_CMP_SPECIAL);
        end
    endfunction

    // Register write data merged by byte lane 0 only
    function [7:0] lane0;
        input [7:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            lane0 = strb[0] ? data[7:0] : old;
        end
    endfunction

    wire timer_on   = timer_cfg[`CFG_ON_BIT];
    wire timer_ext  = timer_cfg[`CFG_EXT_BIT];
    wire ext_rise   = ext_level && !ext_prev;
    wire int_tick   = (div_count == `DIV_COUNT_MAX) && !sleep;
    wire timer_tick = timer_on && (timer_ext ? ext_rise : int_tick);
    wire mode_cap   = is_capture(operating_mode_field);
    wire mode_cmp   = is_compare(operating_mode_field);
    wire cap_rise   = cap_level && !cap_prev;
    wire cap_fall   = !cap_level && cap_prev;
    wire cap_clock_ok = timer_ext || !sleep;
    wire cmp_match  = mode_cmp && !sleep && (value == timer_count_pair);
    reg  cmp_prev_match;
    wire cmp_event  = cmp_match && !cmp_prev_match;

    reg capture_event;
    always @* begin
        capture_event = 1'b0;
        case (operating_mode_field)
            `MODE_CAP_FALL:   capture_event = cap_fall;
            `MODE_CAP_RISE:   capture_event = cap_rise;
            // Rising-edge counter, cleared on control writes: low two bits give every fourth edge
            `MODE_CAP_RISE4:  capture_event = cap_rise &&
                                             (prescale_count[1:0] == `PRESCALE_FOUR);
            `MODE_CAP_RISE16: capture_event = cap_rise &&
                                             (prescale_count == `PRESCALE_SIXTEEN);
            default:          capture_event = 1'b0;
        endcase
        capture_event = capture_event && cap_clock_ok;
    end

    wire       wr_fire  = aw_held && w_held && !s_axi_bvalid;
    wire       wr_ctrl  = wr_fire && (aw_index == `ADDR_CONTROL);
    wire       wr_vlo   = wr_fire && (aw_index == `ADDR_VALUE_LOW);
    wire       wr_vhi   = wr_fire && (aw_index == `ADDR_VALUE_HIGH);
    wire       wr_tlo   = wr_fire && (aw_index == `ADDR_TIMER_LOW);
    wire       wr_thi   = wr_fire && (aw_index == `ADDR_TIMER_HIGH);
    wire       wr_cfg   = wr_fire && (aw_index == `ADDR_TIMER_CFG);
    wire       wr_stat  = wr_fire && (aw_index == `ADDR_IRQ_STATUS);
    wire       wr_mask  = wr_fire && (aw_index == `ADDR_IRQ_MASK);
    wire       wr_map   = (aw_index <= `ADDR_IRQ_MASK);
    wire [7:0] next_ctrl = lane0(capture_compare_control, w_data, w_strb);
    wire [3:0] next_mode = next_ctrl[3:0];

    // Compare actions and flags
    wire match_flag = cmp_event;
    wire special_hit = cmp_event && (operating_mode_field == `MODE_CMP_SPECIAL);
    wire [2:0] irq_set = {special_hit, capture_event, match_flag};

    always @(posedge aclk) begin
        if (!aresetn) begin
            capture_compare_control <= `RESET_BYTE;
            value               <= `RESET_WORD;
            timer_count_pair    <= `RESET_WORD;
            timer_cfg           <= 2'b00;
            irq_status          <= 3'b000;
            irq_mask            <= 3'b000;
            prescale_count      <= 4'h0;
            div_count           <= 2'b00;
            cap_prev            <= 1'b0;
            ext_prev            <= 1'b0;
            cmp_prev_match      <= 1'b0;
            timer_reset_pending <= 1'b0;
            compare_out         <= 1'b0;
            compare_oe          <= 1'b0;
            conversion_start    <= 1'b0;
            irq                 <= 1'b0;
        end else begin
            cap_prev  <= cap_level;
            ext_prev  <= ext_level;
            cmp_prev_match <= cmp_match;
            if (!sleep) begin
                div_count <= div_count + 2'b01;
            end
            // Timer: special trigger reset lands on the next timer tick
            if (wr_tlo) begin
                timer_count_pair[7:0] <= lane0(timer_count_pair[7:0], w_data, w_strb);
            end else if (wr_thi) begin
                timer_count_pair[15:8] <= lane0(timer_count_pair[15:8], w_data, w_strb);
            end else if (timer_tick) begin
                if (timer_reset_pending && cmp_match) begin
                    timer_count_pair <= `RESET_WORD;
                end else begin
                    timer_count_pair <= timer_count_pair + 16'h0001;
                end
            end
            if (special_hit) begin
                timer_reset_pending <= 1'b1;
            end else if (timer_tick || !cmp_match) begin
                timer_reset_pending <= 1'b0;
            end
            conversion_start <= special_hit && converter_enabled;
            // Value register: capture overwrites, software writes bytes
            if (capture_event) begin
                value <= timer_count_pair;
            end else if (wr_vlo) begin
                value[7:0] <= lane0(value[7:0], w_data, w_strb);
            end else if (wr_vhi) begin
                value[15:8] <= lane0(value[15:8], w_data, w_strb);
            end
            if (!mode_cap || wr_ctrl) begin
                prescale_count <= 4'h0;
            end else if (cap_rise && cap_clock_ok) begin
                prescale_count <= prescale_count + 4'h1;
            end
            if (wr_ctrl) begin
                // Off forces latch low; set/clear modes preset the pin
                capture_compare_control <= next_ctrl;
                case (next_mode)
                    `MODE_CMP_SET:    compare_out <= 1'b0;
                    `MODE_CMP_CLEAR:  compare_out <= 1'b1;
                    `MODE_CMP_TOGGLE: compare_out <= compare_out;
                    default:          compare_out <= 1'b0;
                endcase
                compare_oe <= (next_mode == `MODE_CMP_TOGGLE) ||
                              (next_mode == `MODE_CMP_SET) ||
                              (next_mode == `MODE_CMP_CLEAR);
            end else if (cmp_event) begin
                case (operating_mode_field)
                    `MODE_CMP_TOGGLE: compare_out <= !compare_out;
                    `MODE_CMP_SET:    compare_out <= 1'b1;
                    `MODE_CMP_CLEAR:  compare_out <= 1'b0;
                    default:          compare_out <= compare_out;
                endcase
            end
            if (wr_cfg) begin
                timer_cfg <= w_data[1:0];
            end
            if (wr_mask) begin
                irq_mask <= w_data[`IRQ_WIDTH-1:0];
            end
            // Set wins over write-one-to-clear
            if (wr_stat) begin
                irq_status <= (irq_status & ~w_data[`IRQ_WIDTH-1:0]) | irq_set;
            end else begin
                irq_status <= irq_status | irq_set;
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // AXI4-Lite write channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_index      <= 4'h0;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                aw_index      <= s_axi_awaddr[5:2];
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // AXI4-Lite read channel
    reg [7:0] read_byte;
    always @* begin
        read_byte = 8'h00;
        case (s_axi_araddr[5:2])
            `ADDR_CONTROL:    read_byte = capture_compare_control;
            `ADDR_VALUE_LOW:  read_byte = value[7:0];
            `ADDR_VALUE_HIGH: read_byte = value[15:8];
            `ADDR_TIMER_LOW:  read_byte = timer_count_pair[7:0];
            `ADDR_TIMER_HIGH: read_byte = timer_count_pair[15:8];
            `ADDR_TIMER_CFG:  read_byte = {6'h00, timer_cfg};
            `ADDR_IRQ_STATUS: read_byte = {5'h00, irq_status};
            `ADDR_IRQ_MASK:   read_byte = {5'h00, irq_mask};
            default:          read_byte = 8'h00;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h000000, read_byte};
                s_axi_rresp   <= (s_axi_araddr[5:2] <= `ADDR_IRQ_MASK) &&
                                 (s_axi_araddr[31:6] == 26'h0000000) ?
                                 `RESP_OKAY : `RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

// ===== src/ccu_map.vh
// Register map, field positions, mode codes and reset values of the capture/compare unit
`ifndef CCU_MAP_VH
`define CCU_MAP_VH
`define ADDR_CONTROL      4'h0
`define ADDR_VALUE_LOW    4'h1
`define ADDR_VALUE_HIGH   4'h2
`define ADDR_TIMER_LOW    4'h3
`define ADDR_TIMER_HIGH   4'h4
`define ADDR_TIMER_CFG    4'h5
`define ADDR_IRQ_STATUS   4'h6
`define ADDR_IRQ_MASK     4'h7
`define MODE_OFF          4'h0
`define MODE_CMP_TOGGLE   4'h2
`define MODE_CAP_FALL     4'h4
`define MODE_CAP_RISE     4'h5
`define MODE_CAP_RISE4    4'h6
`define MODE_CAP_RISE16   4'h7
`define MODE_CMP_SET      4'h8
`define MODE_CMP_CLEAR    4'h9
`define MODE_CMP_SWI      4'ha
`define MODE_CMP_SPECIAL  4'hb
`define CFG_ON_BIT        0
`define CFG_EXT_BIT       1
`define IRQ_MATCH_BIT     0
`define IRQ_CAPTURE_BIT   1
`define IRQ_SPECIAL_BIT   2
`define IRQ_WIDTH         3
`define PRESCALE_FOUR     2'h3
`define PRESCALE_SIXTEEN  4'hf
`define RESET_BYTE        8'h00
`define RESET_WORD        16'h0000
`define DIV_COUNT_MAX     2'h3
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10
`endif

// ===== src/pin_sync.v
// Three-stage synchroniser with agreement filter for an external pin
`timescale 1ns/10ps
module pin_sync (
    input  wire aclk,
    input  wire aresetn,
    input  wire pin_in,
    output reg  level
);
    reg stage_a;
    reg stage_b;
    reg stage_c;

    always @(posedge aclk) begin
        if (!aresetn) begin
            stage_a <= 1'b0;
            stage_b <= 1'b0;
            stage_c <= 1'b0;
            level   <= 1'b0;
        end else begin
            stage_a <= pin_in;
            stage_b <= stage_a;
            stage_c <= stage_b;
            if (stage_b == stage_c) begin
                level <= stage_c;
            end
        end
    end
endmodule

// ===== tb/ccu_props.sv
// Bus and event checks on the capture/compare unit ports
`timescale 1ns/10ps
module ccu_props (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        sleep,
    input wire        converter_enabled,
    input wire        compare_out,
    input wire        conversion_start
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer_time: assert property (s_write_taken |=> ##1 s_axi_bvalid)
        else $error("write response not two edges after request");
    a_read_answer_time: assert property (s_read_taken |=> s_axi_rvalid)
        else $error("read data not one edge after request");
    a_write_resp_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
        else $error("write response not released after handshake");
    a_read_resp_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read data not released after handshake");
    a_busy_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write accepted while response pending");
    a_trigger_needs_conv: assert property (conversion_start |-> $past(converter_enabled))
        else $error("conversion started while converter disabled");
    a_trigger_one_pulse: assert property (conversion_start |=> !conversion_start)
        else $error("conversion start longer than one cycle");
    a_sleep_pin_frozen: assert property (sleep && $past(sleep) |-> $stable(compare_out))
        else $error("compare output moved during sleep");
endmodule
bind timer_capture_compare_unit ccu_props u_props (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sleep(sleep), .converter_enabled(converter_enabled),
    .compare_out(compare_out), .conversion_start(conversion_start));

// ===== tb/pin_partner.sv
// External capture pin and timer clock source
`timescale 1ns/10ps
module pin_partner (
    input  wire  aclk,
    output logic capture_pin,
    output logic ext_clock_pin
);
    initial begin
        capture_pin = 1'b0;
        ext_clock_pin = 1'b0;
    end
    // Rise then fall, each level held past the synchroniser
    task automatic pulse_capture;
        @(posedge aclk) capture_pin <= 1'b1;
        repeat (8) @(posedge aclk);
        capture_pin <= 1'b0;
        repeat (8) @(posedge aclk);
    endtask
    // Clock stands low outside bursts
    task automatic ext_ticks(input int n);
        repeat (n) begin
            @(posedge aclk) ext_clock_pin <= 1'b1;
            repeat (4) @(posedge aclk);
            ext_clock_pin <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    endtask
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the capture/compare unit
`timescale 1ns/10ps
`include "ccu_map.vh"
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %0t %s", $time, m); end end
module tb_top;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        sleep = 1'b0;
    logic        conv_en = 1'b1;
    logic [31:0] awaddr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] araddr = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        arvalid = 1'b0;
    logic        bready = 1'b0;
    logic        rready = 1'b0;
    wire         awready, wready, bvalid, arready, rvalid, cmp_out, cmp_oe, conv_go, irq;
    wire         cap_pin, ext_pin;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    logic [31:0] rv;
    logic [1:0]  rr;
    int          num_errors = 0;
    int          compares = 0;
    int          conv_seen = 0;
    int          i;
    logic [3:0]  cmodes [5] = '{`MODE_CMP_SET, `MODE_CMP_CLEAR, `MODE_CMP_TOGGLE,
                                `MODE_CMP_SWI, `MODE_CMP_SPECIAL};
    logic        cpre [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic        cpost [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    logic        coe [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    logic [2:0]  cst [5] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h5};
    logic [3:0]  kmodes [4] = '{`MODE_CAP_RISE16, `MODE_CAP_RISE4, `MODE_CAP_FALL, `MODE_CAP_RISE};
    int          kcnt [4] = '{16, 4, 1, 1};

    always #2 aclk = ~aclk;

    // Conversion start pulses seen on the pin
    always @(posedge aclk) begin
        if (conv_go === 1'b1) conv_seen <= conv_seen + 1;
    end

    timer_capture_compare_unit u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sleep(sleep), .ext_clock_pin(ext_pin), .capture_pin(cap_pin),
        .converter_enabled(conv_en), .compare_out(cmp_out), .compare_oe(cmp_oe),
        .conversion_start(conv_go), .irq(irq));
    pin_partner u_pins (.aclk(aclk), .capture_pin(cap_pin), .ext_clock_pin(ext_pin));

    task automatic complete_run;
        $display("Counts: %0d compares, %0d mismatches", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wr(input [3:0] idx, input [7:0] d, input [1:0] e = `RESP_OKAY);
        int n;
        @(posedge aclk);
        awaddr  <= {26'h0, idx, 2'b00};
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (!bvalid && n < 50);
        bready <= 1'b0;
        `CHK(bresp, e, "write response")
        if (n >= 50) begin
            num_errors++;
            complete_run();
        end
    endtask

    task automatic rd(input [3:0] idx);
        int n;
        @(posedge aclk);
        araddr  <= {26'h0, idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (!rvalid && n < 50);
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            complete_run();
        end
    endtask

    task automatic poll(input [2:0] m);
        for (int n = 0; n < 200; n++) begin
            rd(`ADDR_IRQ_STATUS);
            if ((rv[2:0] & m) == m) return;
        end
        num_errors++;
        complete_run();
    endtask

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 8; i++) begin
            rd(i[3:0]);
            `CHK(rv, 32'h0, "reset value")
        end
        rd(4'h8);
        `CHK({rr, rv}, {`RESP_SLVERR, 32'h0}, "unmapped read")
        wr(4'h8, 8'h55, `RESP_SLVERR);
        $display("registers test done");
        wr(`ADDR_TIMER_CFG, 8'h01);
        for (i = 0; i < 5; i++) begin
            wr(`ADDR_CONTROL, 8'h00);
            wr(`ADDR_VALUE_LOW, 8'h40);
            wr(`ADDR_VALUE_HIGH, 8'h00);
            wr(`ADDR_TIMER_HIGH, 8'h00);
            wr(`ADDR_TIMER_LOW, 8'h00);
            wr(`ADDR_CONTROL, {4'h0, cmodes[i]});
            wr(`ADDR_IRQ_STATUS, 8'h07);
            `CHK(cmp_out, cpre[i], "compare preset level")
            poll(3'h1);
            `CHK(cmp_out, cpost[i], "compare pin after match")
            `CHK(cmp_oe, coe[i], "compare pin drive")
            rd(`ADDR_IRQ_STATUS);
            `CHK(rv[2:0], cst[i], "match flags")
        end
        rd(`ADDR_TIMER_LOW);
        `CHK(rv[7:0] < 8'h40, 1'b1, "timer reset by trigger")
        `CHK(conv_seen, 1, "conversion started by trigger")
        wr(`ADDR_CONTROL, 8'h00);
        wr(`ADDR_IRQ_MASK, 8'h04);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b1, "irq raised")
        wr(`ADDR_IRQ_MASK, 8'h00);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b0, "irq masked")
        wr(`ADDR_IRQ_MASK, 8'h04);
        wr(`ADDR_IRQ_STATUS, 8'h04);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b0, "irq cleared")
        rd(`ADDR_IRQ_STATUS);
        `CHK(rv[2:0], 3'h1, "only trigger bit cleared")
        conv_en <= 1'b0;
        wr(`ADDR_TIMER_HIGH, 8'h00);
        wr(`ADDR_TIMER_LOW, 8'h00);
        wr(`ADDR_CONTROL, {4'h0, `MODE_CMP_SPECIAL});
        wr(`ADDR_IRQ_STATUS, 8'h07);
        poll(3'h5);
        repeat (2) @(posedge aclk);
        `CHK(conv_seen, 1, "no conversion while converter off")
        wr(`ADDR_CONTROL, 8'h00);
        $display("compare test done");
        wr(`ADDR_TIMER_CFG, 8'h03);
        wr(`ADDR_TIMER_HIGH, 8'h12);
        wr(`ADDR_TIMER_LOW, 8'h34);
        for (i = 0; i < 4; i++) begin
            wr(`ADDR_CONTROL, 8'h00);
            wr(`ADDR_CONTROL, {4'h0, kmodes[i]});
            wr(`ADDR_IRQ_STATUS, 8'h07);
            repeat (kcnt[i] - 1) u_pins.pulse_capture();
            rd(`ADDR_IRQ_STATUS);
            `CHK(rv[2:0], 3'h0, "no early capture")
            u_pins.pulse_capture();
            rd(`ADDR_IRQ_STATUS);
            `CHK(rv[2:0], 3'h2, "capture flag")
            rd(`ADDR_VALUE_LOW);
            `CHK(rv[7:0], 8'h34, "captured low byte")
            rd(`ADDR_VALUE_HIGH);
            `CHK(rv[7:0], 8'h12, "captured high byte")
            wr(`ADDR_IRQ_STATUS, 8'h07);
            repeat (kcnt[i]) u_pins.pulse_capture();
            rd(`ADDR_IRQ_STATUS);
            `CHK(rv[2:0], 3'h2, "repeated capture")
        end
        sleep <= 1'b1;
        u_pins.ext_ticks(3);
        u_pins.pulse_capture();
        rd(`ADDR_VALUE_LOW);
        `CHK(rv[7:0], 8'h37, "capture in sleep")
        wr(`ADDR_TIMER_CFG, 8'h01);
        wr(`ADDR_TIMER_LOW, 8'h20);
        repeat (40) @(posedge aclk);
        rd(`ADDR_TIMER_LOW);
        `CHK(rv[7:0], 8'h20, "timer frozen in sleep")
        sleep <= 1'b0;
        repeat (40) @(posedge aclk);
        rd(`ADDR_TIMER_LOW);
        `CHK(rv[7:0] > 8'h20, 1'b1, "timer resumes after wake")
        $display("capture test done");
        complete_run();
    end
endmodule
